// ---- core/chan_power_map.svh ----
// Register map, field positions and timing counts of the channel power-on control
`ifndef CHAN_POWER_MAP_SVH
`define CHAN_POWER_MAP_SVH

// Register indices; byte address is four times the index
`define CHAN_A_CFG_INDEX      20'hFE79
`define CHAN_B_CFG_INDEX      20'hFE7A
`define CHAN_A_CFG_ADDR       (`CHAN_A_CFG_INDEX * 20'h4)
`define CHAN_B_CFG_ADDR       (`CHAN_B_CFG_INDEX * 20'h4)
`define CFG_RESET_VALUE       8'h00

// Field positions inside one channel configuration byte
`define CFG_POLARITY_BIT      7
`define CFG_SW_REQUEST_BIT    6
`define CFG_SOURCE_MSB        5
`define CFG_SOURCE_LSB        4
`define CFG_ON_DELAY_MSB      3
`define CFG_ON_DELAY_LSB      2
`define CFG_OFF_DELAY_MSB     1
`define CFG_OFF_DELAY_LSB     0

// Delay codes in milliseconds
`define DELAY_CODE0_MS        10'h000
`define DELAY_CODE1_MS        10'h032
`define DELAY_CODE2_MS        10'h0FA
`define DELAY_CODE3_MS        10'h3E8

// Millisecond tick derived from the 4 ns core clock
`define CLK_PERIOD_PS         4000
`define TICK_PERIOD_PS        1000000000
`define TICK_CYCLES           ((`TICK_PERIOD_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ---- core/chan_power_pkg.sv ----
// Types shared by the channel power-on control modules
package chan_power_pkg;

  typedef enum logic [3:0] {
    ST_OFF      = 4'b0001,
    ST_ON_WAIT  = 4'b0010,
    ST_ON       = 4'b0100,
    ST_OFF_WAIT = 4'b1000
  } chan_state_t;

  typedef enum logic [1:0] {
    SRC_ALWAYS  = 2'h0,
    SRC_PIN     = 2'h1,
    SRC_SW      = 2'h2,
    SRC_BOTH    = 2'h3
  } req_source_t;

endpackage : chan_power_pkg

// ---- core/ms_tick_gen.sv ----
// Millisecond tick divider from the core clock
`timescale 1ns/100ps
`include "chan_power_map.svh"
module ms_tick_gen
  import chan_power_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic reset,
  output logic      tick
);

  logic [17:0] div_r;
  logic        tick_r;
  wire         wrap = (div_r == 18'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      div_r  <= 18'h00000;
      tick_r <= 1'b0;
    end else begin
      div_r  <= wrap ? 18'h00000 : div_r + 18'h00001;
      tick_r <= wrap;
    end
  end

  assign tick = tick_r;

endmodule : ms_tick_gen

// ---- core/chan_delay_ctrl.sv ----
// Per-channel on and off delay sequencer
`timescale 1ns/100ps
`include "chan_power_map.svh"
module chan_delay_ctrl
  import chan_power_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       tick,
  input  wire logic       req,
  input  wire logic [1:0] on_code,
  input  wire logic [1:0] off_code,
  output logic            chan_on
);

  function automatic logic [9:0] delay_ms(input logic [1:0] code);
    case (code)
      2'h0:    delay_ms = `DELAY_CODE0_MS;
      2'h1:    delay_ms = `DELAY_CODE1_MS;
      2'h2:    delay_ms = `DELAY_CODE2_MS;
      default: delay_ms = `DELAY_CODE3_MS;
    endcase
  endfunction : delay_ms

  chan_state_t state_r;
  chan_state_t state_nxt;
  logic [9:0]  cnt_r;
  logic [9:0]  cnt_nxt;
  logic        chan_on_r;

  wire [9:0] on_target  = delay_ms(on_code);
  wire [9:0] off_target = delay_ms(off_code);
  wire [9:0] cnt_inc    = cnt_r + 10'h001;

  // Counter restarts on every entry to a wait state, so a request that
  // toggles before expiry begins the full delay again
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_OFF: begin
        cnt_nxt = 10'h000;
        if (req) begin
          state_nxt = (on_target == 10'h000) ? ST_ON : ST_ON_WAIT; // R7
        end
      end
      ST_ON_WAIT: begin
        if (!req) begin
          state_nxt = ST_OFF; // R11
          cnt_nxt   = 10'h000;
        end else if (tick) begin
          cnt_nxt = cnt_inc;
          if (cnt_inc >= on_target) begin
            state_nxt = ST_ON; // R7
          end
        end
      end
      ST_ON: begin
        cnt_nxt = 10'h000;
        if (!req) begin
          state_nxt = (off_target == 10'h000) ? ST_OFF : ST_OFF_WAIT; // R8
        end
      end
      ST_OFF_WAIT: begin
        if (req) begin
          state_nxt = ST_ON; // R11
          cnt_nxt   = 10'h000;
        end else if (tick) begin
          cnt_nxt = cnt_inc;
          if (cnt_inc >= off_target) begin
            state_nxt = ST_OFF; // R8
          end
        end
      end
      default: begin
        state_nxt = ST_OFF;
        cnt_nxt   = 10'h000;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r   <= ST_OFF;
      cnt_r     <= 10'h000;
      chan_on_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      chan_on_r <= (state_nxt == ST_ON) || (state_nxt == ST_OFF_WAIT);
    end
  end

  assign chan_on = chan_on_r;

  // Helper: ticks seen since the current wait began
  logic [10:0] wait_ticks_r;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wait_ticks_r <= 11'h000;
    end else if (state_r != state_nxt) begin
      wait_ticks_r <= 11'h000;
    end else if (tick) begin
      wait_ticks_r <= wait_ticks_r + 11'h001;
    end
  end

  chk_on_delay_len: assert property ( // R7
    @(posedge core_clk) disable iff (reset)
    (state_r == ST_ON_WAIT) && (state_nxt == ST_ON)
      |-> (wait_ticks_r + 11'h001 == {1'b0, on_target}))
    else $error("on delay did not last the programmed ticks");

  chk_off_delay_len: assert property ( // R8
    @(posedge core_clk) disable iff (reset)
    (state_r == ST_OFF_WAIT) && (state_nxt == ST_OFF)
      |-> (wait_ticks_r + 11'h001 == {1'b0, off_target}))
    else $error("off delay did not last the programmed ticks");

  chk_wait_restart: assert property ( // R11
    @(posedge core_clk) disable iff (reset)
    (state_r == ST_ON_WAIT) && !req |=> (state_r == ST_OFF) && !chan_on)
    else $error("on wait not abandoned when request dropped");

  chk_zero_delay_on: assert property ( // R7
    @(posedge core_clk) disable iff (reset)
    (state_r == ST_OFF) && req && (on_code == 2'h0) |=> chan_on)
    else $error("zero on delay did not turn channel on at once");

endmodule : chan_delay_ctrl

// ---- core/channel_power_on_control.sv ----
// Channel A and B power-on request logic with APB configuration registers
// Behaviour
// R1: Bit 7 inverts request pin polarity; 1 means low pin requests on.
// R2: Bit 6 is the software on request, used when software is a source.
// R3: Source select 00 keeps the channel requested on permanently.
// R4: Source select 01 follows only the polarity-adjusted request pin.
// R5: Source select 10 follows only the software request bit.
// R6: Source select 11 requests on only when pin and software bit both assert.
// R7: Bits 3:2 delay soft start after request: 0, 50, 250, 1000 ms.
// R8: Bits 1:0 delay turn-off after request drop: 0, 50, 250, 1000 ms.
// R9: Channel B has its own identical, independent configuration register.
// R10: System drives each request pin at the programmed polarity when pin control used.
// R11: Delays count millisecond ticks; a request change restarts the count.
`timescale 1ns/100ps
`include "chan_power_map.svh"
module channel_power_on_control
  import chan_power_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [19:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        chan_a_on_request,
  input  wire logic        chan_b_on_request,
  output logic             chan_a_soft_start_en,
  output logic             chan_b_soft_start_en
);

  // Request combining, shared by both channels
  function automatic logic effective_request(input logic [7:0] cfg, input logic pin);
    logic pin_on;
    logic sw_on;
    pin_on = pin ^ cfg[`CFG_POLARITY_BIT];
    sw_on  = cfg[`CFG_SW_REQUEST_BIT];
    case (req_source_t'(cfg[`CFG_SOURCE_MSB:`CFG_SOURCE_LSB]))
      SRC_ALWAYS: effective_request = 1'b1;
      SRC_PIN:    effective_request = pin_on;
      SRC_SW:     effective_request = sw_on;
      SRC_BOTH:   effective_request = pin_on & sw_on;
      default:    effective_request = 1'b1;
    endcase
  endfunction : effective_request

  // Pin synchronisers; first stage feeds only the second
  logic [1:0] pin_meta_r;
  logic [1:0] pin_sync_r;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_meta_r <= 2'h0;
      pin_sync_r <= 2'h0;
    end else begin
      pin_meta_r <= {chan_b_on_request, chan_a_on_request};
      pin_sync_r <= pin_meta_r;
    end
  end

  // Configuration registers
  logic [7:0] cfg_a_r;
  logic [7:0] cfg_b_r;

  // APB slave: one wait state, response registered
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;

  wire         hit_a     = (paddr == `CHAN_A_CFG_ADDR);
  wire         hit_b     = (paddr == `CHAN_B_CFG_ADDR);
  wire         mapped    = hit_a | hit_b;
  wire         access_ph = psel & penable;
  wire         respond   = access_ph & ~pready_r;
  wire         commit    = access_ph & pready_r;
  wire         wr_a      = commit & pwrite & hit_a;
  wire         wr_b      = commit & pwrite & hit_b;
  wire [31:0]  rd_value  = hit_a ? {24'h000000, cfg_a_r} :
                           hit_b ? {24'h000000, cfg_b_r} : 32'h00000000;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= respond;
      prdata_r  <= (respond & ~pwrite) ? rd_value : 32'h00000000;
      pslverr_r <= respond & ~mapped;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_a_r <= `CFG_RESET_VALUE;
      cfg_b_r <= `CFG_RESET_VALUE;
    end else begin
      if (wr_a) begin
        cfg_a_r <= pwdata[7:0];
      end
      if (wr_b) begin
        cfg_b_r <= pwdata[7:0]; // R9
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // Effective requests; pin polarity relies on the system driving it as programmed
  wire req_a = effective_request(cfg_a_r, pin_sync_r[0]); // R1 R2 R3 R4 R5 R6 R10
  wire req_b = effective_request(cfg_b_r, pin_sync_r[1]); // R9

  wire ms_tick;

  ms_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .core_clk (core_clk),
    .reset    (reset),
    .tick     (ms_tick)
  );

  // Tick phase is free-running, so each delay may run short by up to 1 ms
  chan_delay_ctrl u_delay_a (
    .core_clk (core_clk),
    .reset    (reset),
    .tick     (ms_tick),
    .req      (req_a),
    .on_code  (cfg_a_r[`CFG_ON_DELAY_MSB:`CFG_ON_DELAY_LSB]),
    .off_code (cfg_a_r[`CFG_OFF_DELAY_MSB:`CFG_OFF_DELAY_LSB]),
    .chan_on  (chan_a_soft_start_en)
  ); // R7 R8 R11

  chan_delay_ctrl u_delay_b (
    .core_clk (core_clk),
    .reset    (reset),
    .tick     (ms_tick),
    .req      (req_b),
    .on_code  (cfg_b_r[`CFG_ON_DELAY_MSB:`CFG_ON_DELAY_LSB]),
    .off_code (cfg_b_r[`CFG_OFF_DELAY_MSB:`CFG_OFF_DELAY_LSB]),
    .chan_on  (chan_b_soft_start_en)
  ); // R9

  wire [1:0] src_a = cfg_a_r[`CFG_SOURCE_MSB:`CFG_SOURCE_LSB];

  chk_always_on: assert property ( // R3
    @(posedge core_clk) disable iff (reset)
    ((src_a == 2'h0) && (cfg_a_r[3:2] == 2'h0)) [*2] |=> chan_a_soft_start_en)
    else $error("always-on source did not keep channel A on");

  chk_pin_normal: assert property ( // R4
    @(posedge core_clk) disable iff (reset)
    (src_a == 2'h1) && !cfg_a_r[7] |-> req_a == $past(chan_a_on_request, 2))
    else $error("pin source request mismatch on channel A");

  chk_pin_invert: assert property ( // R1
    @(posedge core_clk) disable iff (reset)
    (src_a == 2'h1) && cfg_a_r[7] ##0 $past(chan_a_on_request, 2) == 1'b0
      && $past(reset, 2) == 1'b0 |-> req_a)
    else $error("inverted pin low did not request channel A");

  chk_sw_only: assert property ( // R5
    @(posedge core_clk) disable iff (reset)
    (src_a == 2'h2) |-> req_a == cfg_a_r[6])
    else $error("software source request mismatch on channel A");

  chk_sw_bit: assert property ( // R2
    @(posedge core_clk) disable iff (reset)
    wr_a && pwdata[5:4] == 2'h2 && pwdata[6] |=> req_a)
    else $error("software request write did not request channel A");

  chk_both_needed: assert property ( // R6
    @(posedge core_clk) disable iff (reset)
    (src_a == 2'h3) && !cfg_a_r[6] |-> !req_a)
    else $error("combined source requested without software bit");

  chk_chan_b_indep: assert property ( // R9
    @(posedge core_clk) disable iff (reset)
    wr_a |=> $stable(cfg_b_r))
    else $error("channel A write disturbed channel B register");

  // Checked against the raw pin two edges back, so the synchroniser is covered too
  chk_b_pin_src: assert property ( // R9
    @(posedge core_clk) disable iff (reset)
    (cfg_b_r[5:4] == 2'h1) |-> req_b == ($past(chan_b_on_request, 2) ^ cfg_b_r[7]))
    else $error("pin source request mismatch on channel B");

  chk_apb_wait: assert property (
    @(posedge core_clk) disable iff (reset)
    psel && penable && !pready |=> pready)
    else $error("APB access did not complete after one wait state");

endmodule : channel_power_on_control

// ---- sim/request_pin_model.sv ----
// System-side driver of the two channel request pins
`timescale 1ns/100ps
module request_pin_model (
  input  wire logic core_clk,
  input  wire logic want_a,
  input  wire logic want_b,
  output logic      chan_a_on_request,
  output logic      chan_b_on_request
);
  initial begin
    chan_a_on_request = 1'b0;
    chan_b_on_request = 1'b0;
  end
  // Pins move just after an edge, as a synchronous system board would drive them
  always @(posedge core_clk) begin
    chan_a_on_request <= want_a;
    chan_b_on_request <= want_b;
  end
endmodule : request_pin_model

// ---- sim/channel_power_on_control_tb.sv ----
// Self-checking testbench of the channel power-on control
`timescale 1ns/100ps
`include "chan_power_map.svh"
module channel_power_on_control_tb;
  import chan_power_pkg::*;
  localparam int unsigned TICKS  = 10;
  localparam logic [19:0] ADDR_A = `CHAN_A_CFG_ADDR;
  localparam logic [19:0] ADDR_B = `CHAN_B_CFG_ADDR;
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [19:0] paddr    = 20'h00000;
  logic [31:0] pwdata   = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        want_a   = 1'b0;
  logic        want_b   = 1'b0;
  logic        pin_a;
  logic        pin_b;
  logic        en_a;
  logic        en_b;
  logic [31:0] rd;
  logic        err;
  int          num_errors = 0;
  int          checked    = 0;
  int          cycles     = 0;
  int          ms_of[4]   = '{0, 50, 250, 1000};

  always #2 core_clk = ~core_clk;

  channel_power_on_control #(.TICK_CYCLES(TICKS)) channel_power_on_control_inst (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_a_on_request(pin_a),
    .chan_b_on_request(pin_b), .chan_a_soft_start_en(en_a),
    .chan_b_soft_start_en(en_b));

  request_pin_model request_pin_model_inst (
    .core_clk(core_clk), .want_a(want_a), .want_b(want_b),
    .chan_a_on_request(pin_a), .chan_b_on_request(pin_b));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // Whole run is about 28000 cycles; the ceiling leaves margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      conclude();
    end
  end

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %b", $time, what, got);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h", $time, what, got);
    end
  endtask : chk_word

  task automatic apb(input logic wr, input logic [19:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk_bit(n == 2, 1'b1, "not one wait state");
  endtask : apb

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic test_reset_regs();
    cyc(4);
    chk_bit(en_a, 1'b1, "A on after reset");
    chk_bit(en_b, 1'b1, "B on after reset");
    apb(1'b0, ADDR_A, 32'h0);
    chk_word(rd, 32'h0, "A reset value");
    apb(1'b1, ADDR_A, 32'hFFFFFF0C);
    apb(1'b0, ADDR_A, 32'h0);
    chk_word(rd, 32'h0000000C, "A readback");
    chk_bit(err, 1'b0, "mapped access error");
    apb(1'b1, 20'h00010, 32'h000000FF);
    chk_bit(err, 1'b1, "unmapped write error");
    apb(1'b0, 20'h00010, 32'h0);
    chk_bit(err, 1'b1, "unmapped read error");
    chk_word(rd, 32'h0, "unmapped read data");
    apb(1'b0, ADDR_A, 32'h0);
    chk_word(rd, 32'h0000000C, "A kept after stray write");
    $display("test reset_regs done");
  endtask : test_reset_regs

  task automatic test_sources();
    logic [7:0] cfg;
    logic       eff;
    logic       exp;
    for (int k = 0; k < 32; k++) begin
      cfg = {k[4], k[3], k[2:1], 4'h0};
      want_a <= k[0];
      apb(1'b1, ADDR_A, {24'h0, cfg});
      cyc(8);
      eff = k[0] ^ k[4];
      exp = (k[2:1] == 2'd0) ? 1'b1 : (k[2:1] == 2'd1) ? eff :
            (k[2:1] == 2'd2) ? k[3] : (eff & k[3]);
      chk_bit(en_a, exp, "source select");
    end
    $display("test sources done");
  endtask : test_sources

  task automatic test_chan_b();
    apb(1'b1, ADDR_A, 32'h0);
    want_b <= 1'b1;
    apb(1'b1, ADDR_B, 32'h00000090);
    cyc(8);
    chk_bit(en_b, 1'b0, "B inverted pin high");
    chk_bit(en_a, 1'b1, "A untouched by B");
    want_b <= 1'b0;
    cyc(8);
    chk_bit(en_b, 1'b1, "B inverted pin low");
    apb(1'b0, ADDR_B, 32'h0);
    chk_word(rd, 32'h00000090, "B readback");
    $display("test chan_b done");
  endtask : test_chan_b

  task automatic test_delays();
    for (int c = 1; c < 4; c++) begin
      apb(1'b1, ADDR_A, 32'h00000020);
      cyc(8);
      apb(1'b1, ADDR_A, 32'h00000060 | (c << 2));
      cyc((ms_of[c] - 1) * TICKS - 2);
      chk_bit(en_a, 1'b0, "on too early");
      cyc(TICKS + 6);
      chk_bit(en_a, 1'b1, "on too late");
      apb(1'b1, ADDR_A, 32'h00000020 | c);
      cyc((ms_of[c] - 1) * TICKS - 2);
      chk_bit(en_a, 1'b1, "off too early");
      cyc(TICKS + 6);
      chk_bit(en_a, 1'b0, "off too late");
    end
    $display("test delays done");
  endtask : test_delays

  task automatic test_restart();
    apb(1'b1, ADDR_A, 32'h00000020);
    cyc(8);
    apb(1'b1, ADDR_A, 32'h00000064);
    cyc(30 * TICKS);
    apb(1'b1, ADDR_A, 32'h00000024);
    cyc(8);
    chk_bit(en_a, 1'b0, "aborted on wait");
    apb(1'b1, ADDR_A, 32'h00000064);
    cyc(45 * TICKS);
    chk_bit(en_a, 1'b0, "count not restarted");
    cyc(6 * TICKS);
    chk_bit(en_a, 1'b1, "restarted count");
    apb(1'b1, ADDR_A, 32'h00000021);
    cyc(20 * TICKS);
    chk_bit(en_a, 1'b1, "off wait holds on");
    apb(1'b1, ADDR_A, 32'h00000061);
    cyc(8);
    apb(1'b1, ADDR_A, 32'h00000021);
    cyc(45 * TICKS);
    chk_bit(en_a, 1'b1, "off count not restarted");
    cyc(6 * TICKS);
    chk_bit(en_a, 1'b0, "restarted off count");
    $display("test restart done");
  endtask : test_restart

  initial begin
    cyc(2);
    reset <= 1'b0;
    test_reset_regs();
    test_sources();
    test_chan_b();
    test_delays();
    test_restart();
    conclude();
  end
endmodule : channel_power_on_control_tb
